// ===== src/spc_pkg.sv
// Package of constants for the serial port control block.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
package spc_pkg;
  // --------------------------------------------------------------------
  // Register byte addresses
  // --------------------------------------------------------------------
  localparam logic [7:0] OFF_IRQ_STAT = 8'h_F0;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h_F4;
  localparam logic [7:0] OFF_CTRL     = 8'h_F8;
  localparam logic [7:0] OFF_DATA     = 8'h_FC;
  localparam logic [7:0] CTRL_RESET   = 8'h_00;
  // --------------------------------------------------------------------
  // Control register bit positions
  // --------------------------------------------------------------------
  localparam int BIT_DONE  = 7;
  localparam int BIT_WRITE_COLLISION_FLAG  = 6;
  localparam int BIT_PE    = 5;
  localparam int BIT_MS    = 4;
  localparam int BIT_CLOCK_POLARITY_BIT  = 3;
  localparam int BIT_CLOCK_PHASE_BIT  = 2;
  localparam int BIT_RATEH = 1;
  localparam int BIT_RATEL = 0;
  // Interrupt status bits
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_WRITE_COLLISION_FLAG  = 1;
  // --------------------------------------------------------------------
  // Transfer and timing counts
  // --------------------------------------------------------------------
  localparam int BYTE_BITS      = 8;
  localparam int EDGES_PER_BYTE = 2 * BYTE_BITS;
  // Half serial clock period in system cycles, per rate code; at least
  // three, so returned data has cleared the synchroniser when sampled
  localparam logic [6:0] HALF_R0 = 7'h_04;
  localparam logic [6:0] HALF_R1 = 7'h_08;
  localparam logic [6:0] HALF_R2 = 7'h_20;
  localparam logic [6:0] HALF_R3 = 7'h_40;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h_0;
  localparam logic [1:0] RESP_SLVERR = 2'h_2;
endpackage

// ===== src/spc_pin_if.sv
// Interface carrying synchronised serial pin levels and clock edges.
// Assumes one producer (pin synchroniser) and one consumer (core).
interface spc_pin_if;
  logic sclkLvl;
  logic sclkRise;
  logic sclkFall;
  logic mosiLvl;
  logic misoLvl;
  logic ssNLvl;
  modport sync (output sclkLvl, sclkRise, sclkFall, mosiLvl, misoLvl,
                ssNLvl);
  modport core (input sclkLvl, sclkRise, sclkFall, mosiLvl, misoLvl,
                ssNLvl);
endinterface

// ===== src/spc_pin_sync.sv
// Two-stage synchronisers for the serial pins, plus clock edge detect.
// Assumes pins are asynchronous to clk_sys; nrst synchronous active low.
module spc_pin_sync (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic sclkIn,
  input  wire logic mosiIn,
  input  wire logic misoIn,
  input  wire logic ssNIn,
  spc_pin_if.sync   pins
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic       sclkOld;
  } spc_sync_t;

  spc_sync_t st_ff;
  spc_sync_t nxt_st;

  // --------------------------------------------------------------------
  // Sync stages; edge detect only looks at the second stage
  // --------------------------------------------------------------------
  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.s1      = {ssNIn, misoIn, mosiIn, sclkIn};
    nxt_st.s2      = st_ff.s1;
    nxt_st.sclkOld = st_ff.s2[0];
  end

  // State register; select idles high
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      st_ff <= '{s1: 4'h_8, s2: 4'h_8, sclkOld: 1'b0};
    else
      st_ff <= nxt_st;
  end

  // Outputs to the core
  assign pins.sclkLvl  = st_ff.s2[0];
  assign pins.mosiLvl  = st_ff.s2[1];
  assign pins.misoLvl  = st_ff.s2[2];
  assign pins.ssNLvl   = st_ff.s2[3];
  assign pins.sclkRise = st_ff.s2[0] & ~st_ff.sclkOld;
  assign pins.sclkFall = ~st_ff.s2[0] & st_ff.sclkOld;
endmodule // spc_pin_sync

// ===== src/spc_serial_port.sv
// Serial peripheral port core: master/slave shifter, control register,
// interrupt status/mask and AXI4-Lite slave.
// Assumes pins pass through spc_pin_sync; nrst synchronous active low.
//
// Overview of operation
// - Each serial clock period shifts one bit out and one bit in together.
// - A byte is complete after eight serial clock periods.
// - Clock pin is output as master, input as slave.
// - Master clock rate from rate bits, idle level and phase from control.
// - Data changes on one clock edge and is sampled on the other.
// - Master and slave use the same phase and polarity.
// - Slave shifts only while the low-active select is low.
// - In slave mode, reading rate bit low returns the select pin level.
// - Control bits: done, collision, enable, master, pol, phase, rate.
// - Control register at F8, bit-wise writable, resets to zero.
// - Bytes are eight bits, most significant bit first.
// - Done flag set per transfer; cleared by writing zero or data read.
// - Enable bit chooses this port or the two-wire port on shared pins.
//
// Register access over AXI4-Lite is this design's own decision.
module spc_serial_port (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sclkIn,
  output logic             sclkOut,
  output logic             sclkOe,
  input  wire logic        mosiIn,
  output logic             mosiOut,
  output logic             mosiOe,
  input  wire logic        misoIn,
  output logic             misoOut,
  output logic             misoOe,
  input  wire logic        ssNIn,
  output logic             twoWireSel,
  output logic             irq
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic [7:0]  rdByte;
    logic [4:0]  edges;
    logic [6:0]  div;
    logic        busy;
    logic        sclk;
    logic        outBit;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } spc_core_t;

  spc_core_t st_ff;
  spc_core_t nxt_st;
  spc_pin_if pins ();

  logic       masterMode;
  logic       slaveMode;
  logic       clock_polarity_bit;
  logic       clock_phase_bit;
  logic       tick;
  logic       lead;
  logic       trail;
  logic       sampleEdge;
  logic       inBit;
  logic       wrTake;
  logic       rdTake;
  logic       collide;
  logic       doneEv;
  logic [7:0] ctrlView;

  // Half serial period for a rate code
  function automatic logic [6:0] rateHalf(input logic [1:0] code);
    unique case (code)
      2'b00: rateHalf = spc_pkg::HALF_R0;
      2'b01: rateHalf = spc_pkg::HALF_R1;
      2'b10: rateHalf = spc_pkg::HALF_R2;
      2'b11: rateHalf = spc_pkg::HALF_R3;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------------
  spc_pin_sync u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .sclkIn  (sclkIn),
    .mosiIn  (mosiIn),
    .misoIn  (misoIn),
    .ssNIn   (ssNIn),
    .pins    (pins)
  );

  // --------------------------------------------------------------------
  // Mode decode and edge classification
  // --------------------------------------------------------------------
  assign clock_polarity_bit       = st_ff.ctrl[spc_pkg::BIT_CLOCK_POLARITY_BIT];
  assign clock_phase_bit       = st_ff.ctrl[spc_pkg::BIT_CLOCK_PHASE_BIT];
  assign masterMode = st_ff.ctrl[spc_pkg::BIT_PE]
                      & st_ff.ctrl[spc_pkg::BIT_MS];
  assign slaveMode  = st_ff.ctrl[spc_pkg::BIT_PE]
                      & ~st_ff.ctrl[spc_pkg::BIT_MS];
  assign tick       = masterMode & st_ff.busy & (st_ff.div == 7'h_00);
  // Leading edge leaves the idle level; slave gated by select
  assign lead  = masterMode ? (tick & (st_ff.sclk == clock_polarity_bit))
               : slaveMode & ~pins.ssNLvl
                 & (clock_polarity_bit ? pins.sclkFall : pins.sclkRise);
  assign trail = masterMode ? (tick & (st_ff.sclk != clock_polarity_bit))
               : slaveMode & ~pins.ssNLvl
                 & (clock_polarity_bit ? pins.sclkRise : pins.sclkFall);
  // Phase 0 samples on the leading edge, phase 1 on the trailing
  assign sampleEdge = lead ? ~clock_phase_bit : clock_phase_bit;
  assign inBit      = masterMode ? pins.misoLvl : pins.mosiLvl;
  assign doneEv     = (lead | trail)
                      & (st_ff.edges == 5'(spc_pkg::EDGES_PER_BYTE - 1));
  // Bus handshakes
  assign wrTake = s_axi_awvalid & s_axi_wvalid & ~st_ff.bvalid;
  assign rdTake = s_axi_arvalid & ~st_ff.rvalid;
  assign collide = st_ff.busy | (st_ff.edges != 5'h_00) | lead | trail;
  // Slave reads back the select level in the low rate bit
  assign ctrlView = slaveMode
                    ? {st_ff.ctrl[7:1], pins.ssNLvl} : st_ff.ctrl;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    // Divider paces master clock half periods
    if (st_ff.busy)
      nxt_st.div = (st_ff.div == 7'h_00)
        ? rateHalf(st_ff.ctrl[1:0]) - 7'h_01 : st_ff.div - 7'h_01;
    // Shift engine: one bit in and one bit out per period
    if (lead | trail)
    begin
      if (sampleEdge)
        nxt_st.rx = {st_ff.rx[6:0], inBit};
      else
      begin
        nxt_st.outBit = st_ff.tx[7];
        nxt_st.tx     = {st_ff.tx[6:0], 1'b0};
      end
      if (masterMode)
        nxt_st.sclk = ~st_ff.sclk;
      if (doneEv)
      begin
        nxt_st.edges  = 5'h_00;
        nxt_st.busy   = 1'b0;
        nxt_st.rdByte = nxt_st.rx;
      end
      else
        nxt_st.edges = st_ff.edges + 5'h_01;
    end
    // Select high aborts a slave byte; phase 0 frames each byte
    if (slaveMode & pins.ssNLvl)
      nxt_st.edges = 5'h_00;
    // Idle master clock rests at the polarity level
    if (!st_ff.busy)
      nxt_st.sclk = clock_polarity_bit;
    if (!st_ff.ctrl[spc_pkg::BIT_PE])
    begin
      nxt_st.busy  = 1'b0;
      nxt_st.edges = 5'h_00;
    end
    // Write channel
    if (st_ff.bvalid & s_axi_bready)
      nxt_st.bvalid = 1'b0;
    if (wrTake)
    begin
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = spc_pkg::RESP_OKAY;
      unique case (s_axi_awaddr)
        spc_pkg::OFF_CTRL:
          if (s_axi_wstrb[0])
          begin
            nxt_st.ctrl[5:0] = s_axi_wdata[5:0];
            if (!s_axi_wdata[spc_pkg::BIT_DONE])
              nxt_st.ctrl[spc_pkg::BIT_DONE] = 1'b0;
            if (!s_axi_wdata[spc_pkg::BIT_WRITE_COLLISION_FLAG])
              nxt_st.ctrl[spc_pkg::BIT_WRITE_COLLISION_FLAG] = 1'b0;
          end
        spc_pkg::OFF_DATA:
          if (s_axi_wstrb[0])
          begin
            if (collide)
            begin
              nxt_st.ctrl[spc_pkg::BIT_WRITE_COLLISION_FLAG] = 1'b1;
              nxt_st.stat[spc_pkg::IRQ_WRITE_COLLISION_FLAG] = 1'b1;
            end
            else if (clock_phase_bit)
              nxt_st.tx = s_axi_wdata[7:0];
            else
            begin
              nxt_st.outBit = s_axi_wdata[7];
              nxt_st.tx     = {s_axi_wdata[6:0], 1'b0};
            end
            if (!collide & masterMode)
            begin
              nxt_st.busy  = 1'b1;
              nxt_st.sclk  = clock_polarity_bit;
              nxt_st.edges = 5'h_00;
              nxt_st.div   = rateHalf(st_ff.ctrl[1:0]) - 7'h_01;
            end
          end
        spc_pkg::OFF_IRQ_STAT:
          if (s_axi_wstrb[0])
            nxt_st.stat = st_ff.stat & ~s_axi_wdata[1:0];
        spc_pkg::OFF_IRQ_MASK:
          if (s_axi_wstrb[0])
            nxt_st.mask = s_axi_wdata[1:0];
        default:
          nxt_st.bresp = spc_pkg::RESP_SLVERR;
      endcase
    end
    // Read channel; a data read clears the done flag
    if (st_ff.rvalid & s_axi_rready)
      nxt_st.rvalid = 1'b0;
    if (rdTake)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = spc_pkg::RESP_OKAY;
      nxt_st.rdata  = 32'h_0000_0000;
      unique case (s_axi_araddr)
        spc_pkg::OFF_CTRL:     nxt_st.rdata[7:0] = ctrlView;
        spc_pkg::OFF_IRQ_STAT: nxt_st.rdata[1:0] = st_ff.stat;
        spc_pkg::OFF_IRQ_MASK: nxt_st.rdata[1:0] = st_ff.mask;
        spc_pkg::OFF_DATA:
        begin
          nxt_st.rdata[7:0] = st_ff.rdByte;
          nxt_st.ctrl[spc_pkg::BIT_DONE] = 1'b0;
        end
        default: nxt_st.rresp = spc_pkg::RESP_SLVERR;
      endcase
    end
    // Completion sets flags last so a set beats a same-cycle clear
    if (doneEv)
    begin
      nxt_st.ctrl[spc_pkg::BIT_DONE] = 1'b1;
      nxt_st.stat[spc_pkg::IRQ_DONE] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      st_ff      <= '0;
      st_ff.ctrl <= spc_pkg::CTRL_RESET;
    end
    else
      st_ff <= nxt_st;
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign s_axi_awready = wrTake;
  assign s_axi_wready  = wrTake;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = rdTake;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign sclkOut       = st_ff.sclk;
  assign sclkOe        = masterMode;
  assign mosiOut       = st_ff.outBit;
  assign mosiOe        = masterMode;
  assign misoOut       = st_ff.outBit;
  assign misoOe        = slaveMode & ~pins.ssNLvl;
  assign twoWireSel    = ~st_ff.ctrl[spc_pkg::BIT_PE];
  assign irq           = |(st_ff.stat & st_ff.mask);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_byte_edge_count: assert property ($rose(st_ff.stat[0]) |->
    $past(st_ff.edges) == 5'h_0F) else $error("done without 16 edges");
  a_sclk_direction: assert property (sclkOe ==
    (st_ff.ctrl[5] & st_ff.ctrl[4])) else $error("sclk dir wrong");
  a_idle_polarity: assert property (masterMode & !st_ff.busy
    & $stable(clock_polarity_bit) |=> sclkOut == $past(clock_polarity_bit))
    else $error("idle level");
  a_fast_half_period: assert property (st_ff.busy & masterMode
    & $changed(sclkOut) |=> $stable(sclkOut))
    else $error("half period short");
  a_opposite_edges: assert property (masterMode & lead & !clock_phase_bit
    |=> $stable(mosiOut)) else $error("data moved on sample");
  a_slave_select_gate: assert property (slaveMode & pins.ssNLvl
    |=> st_ff.edges == 5'h_00) else $error("shift without select");
  a_select_readback: assert property (slaveMode |->
    ctrlView[0] == pins.ssNLvl) else $error("select readback");
  a_reset_value: assert property (@(posedge clk_sys) $rose(nrst)
    |-> st_ff.ctrl == 8'h_00) else $error("ctrl reset value");
  a_msb_first: assert property (wrTake & s_axi_awaddr == 8'h_FC
    & !collide & !clock_phase_bit & s_axi_wstrb[0] |=> mosiOut ==
    $past(s_axi_wdata[7])) else $error("msb not first");
  a_done_flag_set: assert property (doneEv |=>
    st_ff.ctrl[7] & st_ff.stat[0]) else $error("done lost");
  a_port_disabled: assert property (!st_ff.ctrl[5] |->
    !sclkOe & !mosiOe & !misoOe) else $error("pins driven");
  a_master_start: assert property (wrTake & s_axi_awaddr == 8'h_FC
    & !collide & masterMode & s_axi_wstrb[0] |=> st_ff.busy)
    else $error("no start");
  a_collision_flag: assert property (wrTake & s_axi_wstrb[0]
    & s_axi_awaddr == spc_pkg::OFF_DATA & st_ff.busy
    |=> st_ff.ctrl[spc_pkg::BIT_WRITE_COLLISION_FLAG]) else $error("collision lost");
  a_read_clears_done: assert property (rdTake & !doneEv
    & s_axi_araddr == spc_pkg::OFF_DATA
    |=> !st_ff.ctrl[spc_pkg::BIT_DONE]) else $error("done not cleared");

  c_master_byte: cover property (masterMode & doneEv);
  c_slave_byte: cover property (slaveMode & doneEv);
  c_collision: cover property ($rose(st_ff.ctrl[6]));
  c_irq_raised: cover property ($rose(irq));
endmodule // spc_serial_port

// ===== tb/spc_spi_partner.sv
// Behavioural far-side device: slave to a master port, master otherwise.
// Assumes the bench resolves each pin from the core's enable; this side has no enables.
module spc_spi_partner (
  input  wire logic sclkPin,
  input  wire logic mosiPin,
  input  wire logic misoPin,
  output logic      sclkDrv,
  output logic      mosiDrv,
  output logic      misoDrv,
  output logic      ssN
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] txSh;
  logic [7:0] rxByte;
  logic       slaveOn = 1'b0;
  logic       mPol;
  logic       mPha;
  logic       lastLvl;
  // Idle pin levels
  initial
  begin
    sclkDrv = 1'b0;
    mosiDrv = 1'b0;
    misoDrv = 1'b0;
    ssN = 1'b1;
  end
  // Slave role: act only on real level changes of the clock pin
  always @(sclkPin)
  begin
    if (slaveOn && sclkPin !== lastLvl)
    begin
      lastLvl = sclkPin;
      if ((sclkPin != mPol) == mPha)
      begin
        if (mPha)
          misoDrv = txSh[7];
        txSh = {txSh[6:0], ~txSh[0]};
        if (!mPha)
          misoDrv = txSh[7];
      end
      else
        rxByte = {rxByte[6:0], mosiPin};
    end
  end
  // Load a reply byte for the slave role
  task automatic slave_load(input logic [7:0] b, input logic p,
                            input logic h);
    mPol = p;
    mPha = h;
    lastLvl = p;
    txSh = b;
    misoDrv = b[7];
    rxByte = 8'h_00;
    slaveOn = 1'b1;
  endtask
  // Master role: one byte at 80 ns per period, clock still outside it
  task automatic master_xfer(input logic [7:0] b, input logic p,
    input logic h, input logic selLow, output logic [7:0] got);
    slaveOn = 1'b0;
    #1 sclkDrv = p;  // Idle level settles before select, off the edge
    #40 ssN = !selLow;
    #100;
    for (int i = 7; i >= 0; i--)
    begin
      if (!h)
        mosiDrv = b[i];
      #40 sclkDrv = !p;
      if (h)
        mosiDrv = b[i];
      else
        got[i] = misoPin;
      #40 sclkDrv = p;
      if (h)
        got[i] = misoPin;
    end
    #40 ssN = h ? ssN : 1'b1;  // phase 1 may keep select low
    mosiDrv = !mosiDrv;  // Released line shows no stale bit
  endtask
  task automatic select(input logic lvl);
    ssN <= lvl;  // select driven as a plain digital level
  endtask
endmodule  // spc_spi_partner

// ===== tb/testbench.sv
// Self-checking bench for the serial port core and a behavioural peer.
// Assumes the design files and tb/spc_spi_partner.sv are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] tx;
    logic [7:0] peer;
    logic [6:0] half;
  } spc_row_t;
  // Master cases: every polarity, phase and rate code once
  localparam spc_row_t ROWS [4] = '{
    '{8'h_30, 8'h_A5, 8'h_3C, spc_pkg::HALF_R0},
    '{8'h_35, 8'h_96, 8'h_C3, spc_pkg::HALF_R1},
    '{8'h_3A, 8'h_01, 8'h_80, spc_pkg::HALF_R2},
    '{8'h_3F, 8'h_FE, 8'h_7F, spc_pkg::HALF_R3}};
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h_00;
  logic [7:0]  s_axi_araddr = 8'h_00;
  logic [31:0] s_axi_wdata = 32'h_0000_0000;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdv;
  logic        sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe;
  logic        twoWireSel, irq, ssN, peerSclk, peerMosi, peerMiso;
  logic        sclkPin, mosiPin, misoPin, prevClk, curPol;
  logic [7:0]  got;
  int          error_cnt = 0, check_count = 0, cycles = 0;
  int          cnt = 0, halfCnt = 0, edges = 0;

  always #2.5 clk_sys = ~clk_sys;
  // Pin levels from the core's enables; the peer drives otherwise
  assign sclkPin = (sclkOe === 1'b1) ? sclkOut : peerSclk;
  assign mosiPin = (mosiOe === 1'b1) ? mosiOut : peerMosi;
  assign misoPin = (misoOe === 1'b1) ? misoOut : peerMiso;

  spc_serial_port i_spc_serial_port (.clk_sys, .nrst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h_F),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sclkIn(sclkPin), .sclkOut, .sclkOe, .mosiIn(mosiPin), .mosiOut,
    .mosiOe, .misoIn(misoPin), .misoOut, .misoOe, .ssNIn(ssN),
    .twoWireSel, .irq);
  spc_spi_partner i_partner (.sclkPin, .mosiPin, .misoPin,
    .sclkDrv(peerSclk), .mosiDrv(peerMosi), .misoDrv(peerMiso), .ssN);

  // Clock toggle monitor, leading edge count and timeout
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    prevClk <= sclkOut;
    if (sclkOe === 1'b1 && sclkOut !== prevClk)
    begin
      halfCnt <= cnt;
      cnt <= 1;
      if (sclkOut !== curPol)
        edges <= edges + 1;
    end
    else
      cnt <= cnt + 1;
    if (cycles == 60000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Bus write: both channels together, then the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(n, rdv & m, e);
  endtask
  task automatic wait_irq;
    repeat (3000)
    begin
      @(posedge clk_sys);
      if (irq === 1'b1)
        break;
    end
    chk("irqUp", irq, 1);
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rdchk("ctrlRst", spc_pkg::OFF_CTRL, 32'h_FFFF_FFFF, 0);
    chk("twoWireRst", twoWireSel, 1);
    chk("sclkOeRst", sclkOe, 0);
    wr(8'h_10, 32'h_0000_00FF);
    chk("bresp", resp, spc_pkg::RESP_SLVERR);
    rdchk("unmapped", 8'h_10, 32'h_FFFF_FFFF, 0);
    chk("rresp", resp, spc_pkg::RESP_SLVERR);
    foreach (ROWS[k])
    begin
      wr(spc_pkg::OFF_IRQ_MASK, 1);
      wr(spc_pkg::OFF_CTRL, ROWS[k].ctrl);
      curPol = ROWS[k].ctrl[3];
      repeat (2) @(posedge clk_sys);
      chk("twoWireOn", twoWireSel, 0);
      chk("sclkOeM", sclkOe, 1);
      chk("mosiOeM", mosiOe, 1);
      i_partner.slave_load(ROWS[k].peer, curPol, ROWS[k].ctrl[2]);
      edges = 0;
      wr(spc_pkg::OFF_DATA, ROWS[k].tx);
      wait_irq();
      chk("leadEdges", edges, 8);
      chk("halfPer", halfCnt, ROWS[k].half);
      chk("idleLvl", sclkPin, curPol);
      chk("peerRx", i_partner.rxByte, ROWS[k].tx);
      rdchk("doneSet", spc_pkg::OFF_CTRL, 32'h_80, 32'h_80);
      rdchk("stat", spc_pkg::OFF_IRQ_STAT, 3, 1);
      rdchk("rxData", spc_pkg::OFF_DATA, 32'h_FF, ROWS[k].peer);
      rdchk("doneClr", spc_pkg::OFF_CTRL, 32'h_80, 0);
      wr(spc_pkg::OFF_IRQ_STAT, 1);
      repeat (2) @(posedge clk_sys);
      chk("irqClr", irq, 0);
    end
    // Collision while busy, masked interrupt, clear by writing zero
    wr(spc_pkg::OFF_IRQ_MASK, 0);
    wr(spc_pkg::OFF_CTRL, 32'h_31);
    curPol = 1'b0;
    i_partner.slave_load(8'h_5A, 1'b0, 1'b0);
    wr(spc_pkg::OFF_DATA, 32'h_C6);
    wr(spc_pkg::OFF_DATA, 32'h_11);
    rdchk("write_collision_flag", spc_pkg::OFF_CTRL, 32'h_C0, 32'h_40);
    for (int i = 0; i < 100 && rdv[7] !== 1'b1; i++)
      rd(spc_pkg::OFF_CTRL);
    chk("irqMasked", irq, 0);
    chk("keptByte", i_partner.rxByte, 8'h_C6);
    rdchk("stat2", spc_pkg::OFF_IRQ_STAT, 3, 3);
    wr(spc_pkg::OFF_IRQ_MASK, 2);
    repeat (2) @(posedge clk_sys);
    chk("irqWcol", irq, 1);
    wr(spc_pkg::OFF_CTRL, 32'h_31);
    rdchk("flagsClr", spc_pkg::OFF_CTRL, 32'h_C0, 0);
    wr(spc_pkg::OFF_IRQ_STAT, 3);
    repeat (2) @(posedge clk_sys);
    chk("irqOff", irq, 0);
    // Slave role, both phases, clock set to match the outside master
    for (int h = 0; h < 2; h++)
    begin
      wr(spc_pkg::OFF_CTRL, (h != 0) ? 32'h_2C : 32'h_20);
      repeat (2) @(posedge clk_sys);
      chk("sclkOeS", sclkOe, 0);
      chk("mosiOeS", mosiOe, 0);
      rdchk("selHigh", spc_pkg::OFF_CTRL, 1, 1);
      wr(spc_pkg::OFF_DATA, 32'h_B4 ^ h);
      i_partner.master_xfer(8'h_69, h[0], h[0], 1'b1, got);
      @(posedge clk_sys);
      chk("slvOut", got, 32'h_B4 ^ h);
      rdchk("slvDone", spc_pkg::OFF_CTRL, 32'h_80, 32'h_80);
      rdchk("slvRx", spc_pkg::OFF_DATA, 32'h_FF, 32'h_69);
    end
    // Phase 1 second byte with select still low from the last one
    wr(spc_pkg::OFF_DATA, 32'h_5A);
    i_partner.master_xfer(8'h_C3, 1'b1, 1'b1, 1'b1, got);
    @(posedge clk_sys);
    chk("slvOutHeld", got, 32'h_5A);
    rdchk("slvRxHeld", spc_pkg::OFF_DATA, 32'h_FF, 32'h_C3);
    i_partner.select(1'b1);
    // Unselected slave ignores a whole byte of clocks
    wr(spc_pkg::OFF_CTRL, 32'h_20);
    wr(spc_pkg::OFF_DATA, 32'h_3C);
    i_partner.master_xfer(8'h_FF, 1'b0, 1'b0, 1'b0, got);
    @(posedge clk_sys);
    rdchk("noSel", spc_pkg::OFF_CTRL, 32'h_80, 0);
    chk("misoOeOff", misoOe, 0);
    i_partner.select(1'b0);
    repeat (8) @(posedge clk_sys);
    rdchk("selLow", spc_pkg::OFF_CTRL, 1, 0);
    i_partner.select(1'b1);
    wrap_up();
  end
endmodule  // testbench
